/* rgcr_pkg.sv */
// Purpose: constants and types for the regulator control register bank
// Assumes: byte-wide register port, 9-bit register address
// Notes: reset values of the registers are neutral parameters of the top
package rgcr_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam logic [8:0] OFS_REG2_CTRL = 9'h027;
	localparam logic [8:0] OFS_REG3_CTRL = 9'h028;
	localparam logic [8:0] OFS_REG4_CTRL = 9'h029;
	localparam logic [8:0] OFS_VSET_SEL = 9'h032;
	// regulator control field positions
	localparam int BIT_ON = 0;
	localparam int BIT_EN_SEL_LO = 1;
	localparam int BIT_PD_OFF = 3;
	localparam int BIT_V_SEL_LO = 5;
	localparam int BIT_DEF_SEQ = 7;
	localparam logic [7:0] CTRL_WMASK = 8'hef;
	localparam logic [7:0] VSET_WMASK = 8'hfd;
	// voltage-select bit positions for the three regulators handled here
	localparam int VSEL_REG2 = 5;
	localparam int NUM_REG = 3;
	localparam logic [1:0] SEL_SEQUENCER = 2'h0;
	localparam int NUM_GPI = 3;

	typedef struct packed {
		logic default_or_sequenced;
		logic [1:0] voltage_input_sel;
		logic reserved;
		logic pulldown_off;
		logic [1:0] enable_input_sel;
		logic on;
	} rgcr_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [8:0] addr;
		logic [7:0] wdata;
	} rgcr_req_t;
endpackage : rgcr_pkg

/* rgcr_gpi_edge.sv */
// Purpose: synchronise one general-purpose input and flag its edges
// Assumes: input is asynchronous to clock
// Notes: three stages; a change counts when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module rgcr_gpi_edge (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// pin
	input wire logic pin,
	// edge flags
	output logic rise,
	output logic fall
);
	logic [2:0] sync;
	logic level;
	logic [2:0] next_sync;
	logic next_level;

	always_comb begin
		next_sync = {sync[1:0], pin};
		next_level = level;
		if (sync[1] == sync[2])
			next_level = sync[2];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync <= 3'h0;
			level <= 1'b0;
		end else begin
			sync <= next_sync;
			level <= next_level;
		end
	end

	assign rise = next_level & ~level;
	assign fall = ~next_level & level;
endmodule : rgcr_gpi_edge
`default_nettype wire

/* rgcr_regs.sv */
// Purpose: control registers for regulators 2..4 and the shared voltage-set select
// Assumes: host port gives one-cycle read/write strobes on the register clock
// Notes: input edges and host writes land in the same bits; host write wins
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - bits 6:5 pick the voltage-switching input: 00 sequencer, 01..11 inputs one..three.
// - selected input rising chooses set A, falling chooses set B.
// - bits 2:1 pick enabling input; rising enables, falling disables, 00 sequencer.
// - bit 0 disables (0) or enables (1) the regulator, subject to priority order.
// - bit 7 marks the regulator default supply or sequenced and on in low power.
// - bit 3 decides whether the pull-down stays engaged while the regulator is off.
// - select register holds one A/B bit per supply; 0 means A, 1 means B.
module rgcr_regs #(
	parameter logic [7:0] CTRL_RESET = 8'h00,
	parameter logic [7:0] VSET_RESET = 8'h00
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// host register port
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [8:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	// general-purpose inputs
	input wire logic general_input_one,
	input wire logic general_input_two,
	input wire logic general_input_three,
	// regulator controls to the sequencer and analog
	output logic [2:0] reg_on,
	output logic [2:0] reg_default_or_sequenced,
	output logic [2:0] reg_pulldown_off,
	output logic [2:0] reg_enable_seq_ctrl,
	output logic [2:0] reg_voltage_seq_ctrl,
	output logic [7:0] voltage_set_b
);
	localparam rgcr_pkg::rgcr_ctrl_t CTRL_INIT = CTRL_RESET & rgcr_pkg::CTRL_WMASK;
	localparam logic [7:0] VSET_INIT = VSET_RESET & rgcr_pkg::VSET_WMASK;
	localparam logic EN_SEQ_INIT = CTRL_INIT.enable_input_sel == rgcr_pkg::SEL_SEQUENCER;
	localparam logic V_SEQ_INIT = CTRL_INIT.voltage_input_sel == rgcr_pkg::SEL_SEQUENCER;

	// register state
	rgcr_pkg::rgcr_ctrl_t ctrl [rgcr_pkg::NUM_REG];
	rgcr_pkg::rgcr_ctrl_t next_ctrl [rgcr_pkg::NUM_REG];
	logic [7:0] vset;
	logic [7:0] next_vset;
	// read port state
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic rvalid;
	logic next_rvalid;
	// registered decodes of the input-select fields
	logic [rgcr_pkg::NUM_REG-1:0] en_seq;
	logic [rgcr_pkg::NUM_REG-1:0] next_en_seq;
	logic [rgcr_pkg::NUM_REG-1:0] v_seq;
	logic [rgcr_pkg::NUM_REG-1:0] next_v_seq;
	// synchronised input edges
	logic [rgcr_pkg::NUM_GPI-1:0] gpi_pins;
	logic [rgcr_pkg::NUM_GPI-1:0] gpi_rise;
	logic [rgcr_pkg::NUM_GPI-1:0] gpi_fall;
	// per-regulator events taken from the selected input
	logic [rgcr_pkg::NUM_REG-1:0] en_rise;
	logic [rgcr_pkg::NUM_REG-1:0] en_fall;
	logic [rgcr_pkg::NUM_REG-1:0] v_rise;
	logic [rgcr_pkg::NUM_REG-1:0] v_fall;
	// host address hits
	logic [rgcr_pkg::NUM_REG-1:0] ctrl_addr_hit;
	logic [rgcr_pkg::NUM_REG-1:0] ctrl_wr_hit;
	logic vset_addr_hit;
	logic vset_wr_hit;
	rgcr_pkg::rgcr_req_t req;

	assign gpi_pins = {general_input_three, general_input_two, general_input_one};
	assign req = '{wr: host_wr, rd: host_rd, addr: host_addr, wdata: host_wdata};

	genvar g;
	generate
		for (g = 0; g < rgcr_pkg::NUM_GPI; g++) begin : gen_gpi
			rgcr_gpi_edge u_edge (
				.clock(clock),
				.resetn(resetn),
				.pin(gpi_pins[g]),
				.rise(gpi_rise[g]),
				.fall(gpi_fall[g])
			);
		end
	endgenerate

	function automatic logic [8:0] ctrl_ofs(input int idx);
		logic [8:0] r;
		r = rgcr_pkg::OFS_REG2_CTRL;
		if (idx == 1)
			r = rgcr_pkg::OFS_REG3_CTRL;
		if (idx == 2)
			r = rgcr_pkg::OFS_REG4_CTRL;
		return r;
	endfunction : ctrl_ofs

	// selected input edges; code 00 leaves the field to the sequencer
	function automatic logic sel_edge(input logic [1:0] sel, input logic [2:0] edges);
		logic r;
		r = 1'b0;
		if (sel != rgcr_pkg::SEL_SEQUENCER)
			r = edges[sel - 2'h1];
		return r;
	endfunction : sel_edge

	// address decode shared by the write and read paths
	always_comb begin
		for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
			ctrl_addr_hit[i] = req.addr == ctrl_ofs(i);
			ctrl_wr_hit[i] = req.wr && ctrl_addr_hit[i];
		end
		vset_addr_hit = req.addr == rgcr_pkg::OFS_VSET_SEL;
		vset_wr_hit = req.wr && vset_addr_hit;
	end

	// each regulator listens only to the input its select field names
	always_comb begin
		for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
			en_rise[i] = sel_edge(ctrl[i].enable_input_sel, gpi_rise);
			en_fall[i] = sel_edge(ctrl[i].enable_input_sel, gpi_fall);
			v_rise[i] = sel_edge(ctrl[i].voltage_input_sel, gpi_rise);
			v_fall[i] = sel_edge(ctrl[i].voltage_input_sel, gpi_fall);
		end
	end

	// host write wins over an input edge in the same cycle
	always_comb begin
		for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
			next_ctrl[i] = ctrl[i];
			if (en_rise[i])
				next_ctrl[i].on = 1'b1;
			else if (en_fall[i])
				next_ctrl[i].on = 1'b0;
			if (ctrl_wr_hit[i])
				next_ctrl[i] = req.wdata & rgcr_pkg::CTRL_WMASK;
		end
	end

	// select bits of regulators 2..4 follow their inputs; the others only the host
	always_comb begin
		next_vset = vset;
		for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
			if (v_rise[i])
				next_vset[rgcr_pkg::VSEL_REG2 + i] = 1'b0;
			else if (v_fall[i])
				next_vset[rgcr_pkg::VSEL_REG2 + i] = 1'b1;
		end
		if (vset_wr_hit)
			next_vset = req.wdata & rgcr_pkg::VSET_WMASK;
	end

	// decodes taken from the next field values so they move with the field
	always_comb begin
		for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
			next_en_seq[i] = next_ctrl[i].enable_input_sel == rgcr_pkg::SEL_SEQUENCER;
			next_v_seq[i] = next_ctrl[i].voltage_input_sel == rgcr_pkg::SEL_SEQUENCER;
		end
	end

	// read data holds until the next read; unmapped addresses read zero
	always_comb begin
		next_rvalid = req.rd;
		next_rdata = rdata;
		if (req.rd) begin
			next_rdata = 8'h00;
			for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
				if (ctrl_addr_hit[i])
					next_rdata = ctrl[i] & rgcr_pkg::CTRL_WMASK;
			end
			if (vset_addr_hit)
				next_rdata = vset & rgcr_pkg::VSET_WMASK;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
				ctrl[i] <= CTRL_INIT;
			end
			en_seq <= {rgcr_pkg::NUM_REG{EN_SEQ_INIT}};
			v_seq <= {rgcr_pkg::NUM_REG{V_SEQ_INIT}};
		end else begin
			for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
				ctrl[i] <= next_ctrl[i];
			end
			en_seq <= next_en_seq;
			v_seq <= next_v_seq;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			vset <= VSET_INIT;
		else
			vset <= next_vset;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// outputs straight from the flops; priority ordering lives in the sequencer
	always_comb begin
		for (int i = 0; i < rgcr_pkg::NUM_REG; i++) begin
			reg_on[i] = ctrl[i].on;
			reg_default_or_sequenced[i] = ctrl[i].default_or_sequenced;
			reg_pulldown_off[i] = ctrl[i].pulldown_off;
		end
	end
	assign reg_enable_seq_ctrl = en_seq;
	assign reg_voltage_seq_ctrl = v_seq;
	assign voltage_set_b = vset;
	assign host_rdata = rdata;
	assign host_rvalid = rvalid;
endmodule : rgcr_regs
`default_nettype wire

/* rgcr_regs_asserts.sv */
// Purpose: checks on the regulator register bank
// Assumes: host strobes are one cycle
// Notes: only regulator 2 is traced, except the reserved-bit read check on all three
`timescale 1ns/10ps
`default_nettype none
module rgcr_regs_asserts (
	// host side
	input wire logic clock,
	input wire logic resetn,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [8:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid,
	// controls
	input wire logic [2:0] reg_on,
	input wire logic [2:0] reg_default_or_sequenced,
	input wire logic [2:0] reg_pulldown_off,
	input wire logic [2:0] reg_enable_seq_ctrl,
	input wire logic [2:0] reg_voltage_seq_ctrl,
	input wire logic [7:0] voltage_set_b
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	wire w2 = host_wr && host_addr == 9'h027;
	a_on_write: assert property (w2 |=> reg_on[0] == $past(host_wdata[0])) else $error("on");
	a_pd_write: assert property (w2 |=> reg_pulldown_off[0] == $past(host_wdata[3])) else $error("pd");
	a_def_write: assert property (w2 |=> reg_default_or_sequenced[0] == $past(host_wdata[7])) else $error("def");
	a_en_decode: assert property (w2 |=> reg_enable_seq_ctrl[0] == ($past(host_wdata[2:1]) == 2'h0))
		else $error("en sel");
	a_v_decode: assert property (w2 |=> reg_voltage_seq_ctrl[0] == ($past(host_wdata[6:5]) == 2'h0))
		else $error("v sel");
	a_vset_write: assert property (
		host_wr && host_addr == 9'h032 |=> voltage_set_b == ($past(host_wdata) & 8'hfd)) else $error("vset");
	a_resv_zero: assert property (
		host_rd && host_addr inside {9'h027, 9'h028, 9'h029} |=> host_rvalid && !host_rdata[4]) else $error("resv");
	a_seq_hold: assert property (reg_enable_seq_ctrl[0] && !w2 |=> $stable(reg_on[0])) else $error("hold");
endmodule : rgcr_regs_asserts
bind rgcr_regs rgcr_regs_asserts u_chk (.*);
`default_nettype wire

/* rgcr_pin_model.sv */
// Purpose: board side driving the input pins
// Assumes: bench sets wanted levels
// Notes: small delay, pins never move on an edge
`timescale 1ns/10ps
`default_nettype none
module rgcr_pin_model (
	// levels in, pins out
	input wire logic [2:0] level,
	output wire logic [2:0] pin
);
	assign #2 pin = level;
endmodule : rgcr_pin_model
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench of the register bank
// Assumes: register reset values 0
// Notes: pins pass through the pin model
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock = 1'b0, resetn = 1'b0, host_wr = 1'b0, host_rd = 1'b0, host_rvalid;
	logic [8:0] host_addr = 9'h000;
	logic [7:0] host_wdata = 8'h00, host_rdata, voltage_set_b;
	logic [2:0] level = 3'h0, pin, reg_on, reg_def, reg_pd, reg_en_seq, reg_v_seq;
	int error_cnt = 0, checks = 0;
	rgcr_pin_model u_pin (.level(level), .pin(pin));
	rgcr_regs u_dut (.clock(clock), .resetn(resetn), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .general_input_one(pin[0]),
		.general_input_two(pin[1]), .general_input_three(pin[2]), .reg_on(reg_on),
		.reg_default_or_sequenced(reg_def), .reg_pulldown_off(reg_pd), .reg_enable_seq_ctrl(reg_en_seq),
		.reg_voltage_seq_ctrl(reg_v_seq), .voltage_set_b(voltage_set_b));
	initial begin
		forever #5 clock = ~clock;
	end
	task cmp(input logic [8:0] g, input logic [8:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clock);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clock);
		host_wr <= 1'b0;
	endtask : wr
	task rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clock);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clock);
		host_rd <= 1'b0;
		#1 cmp({host_rvalid, host_rdata}, {1'b1, e});
	endtask : rd
	// pin path is a few cycles of sync, so poll with a bound
	task wt(input int r, input logic v);
		for (int i = 0; i < 20 && reg_on[r] !== v; i++) @(posedge clock) #1;
		cmp({8'h00, reg_on[r]}, {8'h00, v});
	endtask : wt
	task print_verdict;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task t_regs;
		logic [8:0] a;
		for (int i = 0; i < 4; i++) begin
			a = i < 3 ? 9'h027 + 9'(i) : 9'h032;
			rd(a, 8'h00);
			if (i < 3) cmp({4'h0, reg_def[i], reg_pd[i], reg_en_seq[i], reg_v_seq[i], reg_on[i]}, 9'h006);
			wr(a, 8'hff);
			rd(a, i < 3 ? 8'hef : 8'hfd);
			if (i < 3) cmp({4'h0, reg_def[i], reg_pd[i], reg_en_seq[i], reg_v_seq[i], reg_on[i]}, 9'h019);
		end
		rd(9'h030, 8'h00);
		$display("regs done");
	endtask : t_regs
	task t_pin;
		for (int k = 1; k < 4; k++) begin
			wr(9'h026 + 9'(k), {1'b0, 2'(k), 2'h0, 2'(k), 1'b0});
			wr(9'h032, 8'(8'h10 << k));
			@(posedge clock) level[k-1] <= 1'b1;
			wt(k - 1, 1'b1);
			cmp({8'h00, voltage_set_b[4 + k]}, 9'h000);
			@(posedge clock) level[k-1] <= 1'b0;
			wt(k - 1, 1'b0);
			cmp({8'h00, voltage_set_b[4 + k]}, 9'h001);
		end
		$display("pins done");
	endtask : t_pin
	initial begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		t_regs;
		t_pin;
		print_verdict;
	end
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
endmodule : tb
`default_nettype wire
